// >>> rtl/pei_avs_slave.sv
// pei_avs_slave: avalon-mm slave front end with one wait cycle
// assumes the master holds its request until waitrequest is seen low
`timescale 1ns/1ps
`default_nettype none
module pei_avs_slave
   import pei_pkg::*;
(
   input  wire logic      i_sys_clk,
   input  wire logic      i_srst,
   input  wire logic      i_clk_en,
   input  wire pei_addr_t i_avs_address,
   input  wire logic      i_avs_read,
   input  wire logic      i_avs_write,
   input  wire pei_data_t i_avs_writedata,
   input  wire logic [3:0] i_avs_byteenable,
   output pei_data_t      o_avs_readdata,
   output logic           o_avs_waitrequest,
   pei_reg_if.bus         reg_port
);

   pei_bus_e state;
   logic     req;

   assign req = i_avs_read | i_avs_write;

   // accept strobes fire at the edge where waitrequest is low
   assign reg_port.rd    = (state == PEI_BUS_ACK) & i_avs_read;
   assign reg_port.wr    = (state == PEI_BUS_ACK) & i_avs_write;
   assign reg_port.addr  = i_avs_address;
   assign reg_port.wdata = i_avs_writedata;
   assign reg_port.be    = i_avs_byteenable;

   // handshake: sample request, drop waitrequest one cycle, re-arm
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state             <= PEI_BUS_IDLE;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= PEI_RST_RDATA;
      end
      else if (i_clk_en)
      begin
         case (state)
            PEI_BUS_IDLE:
            begin
               if (req)
               begin
                  state             <= PEI_BUS_ACK;
                  o_avs_waitrequest <= 1'b0;
                  o_avs_readdata    <= reg_port.rdata;
               end
            end
            PEI_BUS_ACK:
            begin
               state             <= PEI_BUS_IDLE;
               o_avs_waitrequest <= 1'b1;
            end
            default:
            begin
               state             <= PEI_BUS_IDLE;
               o_avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

endmodule : pei_avs_slave
`default_nettype wire

// >>> rtl/pei_event_irq.sv
// pei_event_irq: interrupt status of a three-timer pwm unit
// assumes event inputs are one-cycle pulses from logic on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module pei_event_irq
   import pei_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_clk_en,
   // event pulses, one bit per unit
   input  wire logic [2:0] i_capture,
   input  wire logic [2:0] i_one_shot_trip,
   input  wire logic [2:0] i_cycle_trip,
   input  wire logic [2:0] i_operator_compare_a_event,
   input  wire logic [2:0] i_operator_compare_b_event,
   input  wire logic [2:0] i_fault_start,
   input  wire logic [2:0] i_fault_end,
   input  wire logic [2:0] i_timer_zero_event,
   input  wire logic [2:0] i_timer_peak_event,
   input  wire logic [2:0] i_timer_halt,
   // avalon-mm slave
   input  wire pei_addr_t  i_avs_address,
   input  wire logic       i_avs_read,
   input  wire logic       i_avs_write,
   input  wire pei_data_t  i_avs_writedata,
   input  wire logic [3:0] i_avs_byteenable,
   output pei_data_t       o_avs_readdata,
   output logic            o_avs_waitrequest,
   // interrupt request
   output logic            o_irq
);

   // -----------------------------------------------------------------
   // internal signals
   // -----------------------------------------------------------------
   pei_reg_if  rif ();
   pei_flags_t evt_vec;     // all event pulses in register layout
   pei_flags_t raw;         // raw_event_flags
   pei_flags_t ena;         // event_enable_word
   pei_flags_t masked;      // masked_event_flags
   pei_flags_t clr_vec;     // clear requests this cycle
   pei_flags_t w1c_vec;     // clear from a write of ones
   pei_flags_t roc_vec;     // clear from a read of the masked word
   pei_data_t  be_mask;     // byte enables spread to bits
   logic       hit_ena;
   logic       hit_raw;
   logic       hit_st;
   logic       hit_clr;

   // -----------------------------------------------------------------
   // event gathering
   // -----------------------------------------------------------------

   // place each group at its field; bit 29 down to bit 0
   always_comb
   begin
      evt_vec = '0;
      evt_vec[PEI_POS_CAPTURE   +: 3] = i_capture;
      evt_vec[PEI_POS_ONE_SHOT  +: 3] = i_one_shot_trip;
      evt_vec[PEI_POS_CYCLE     +: 3] = i_cycle_trip;
      evt_vec[PEI_POS_CMP_B     +: 3] = i_operator_compare_b_event;
      evt_vec[PEI_POS_CMP_A     +: 3] = i_operator_compare_a_event;
      evt_vec[PEI_POS_FAULT_END +: 3] = i_fault_end;
      evt_vec[PEI_POS_FAULT_BEG +: 3] = i_fault_start;
      evt_vec[PEI_POS_PEAK      +: 3] = i_timer_peak_event;
      evt_vec[PEI_POS_ZERO      +: 3] = i_timer_zero_event;
      evt_vec[PEI_POS_HALT      +: 3] = i_timer_halt;
   end

   // -----------------------------------------------------------------
   // bus front end
   // -----------------------------------------------------------------

   // handshake and read data register
   pei_avs_slave u_slave (
      .i_sys_clk         (i_sys_clk),
      .i_srst            (i_srst),
      .i_clk_en          (i_clk_en),
      .i_avs_address     (i_avs_address),
      .i_avs_read        (i_avs_read),
      .i_avs_write       (i_avs_write),
      .i_avs_writedata   (i_avs_writedata),
      .i_avs_byteenable  (i_avs_byteenable),
      .o_avs_readdata    (o_avs_readdata),
      .o_avs_waitrequest (o_avs_waitrequest),
      .reg_port          (rif.bus)
   );

   // address decode on the full byte address
   assign hit_ena = (rif.addr == PEI_OFF_ENA);
   assign hit_raw = (rif.addr == PEI_OFF_RAW);
   assign hit_st  = (rif.addr == PEI_OFF_ST);
   assign hit_clr = (rif.addr == PEI_OFF_CLR);

   // byte enables spread to a bit mask
   assign be_mask = {{8{rif.be[3]}}, {8{rif.be[2]}},
                     {8{rif.be[1]}}, {8{rif.be[0]}}};

   // read mux; clear word reads as zero, unmapped reads as zero
   always_comb
   begin
      rif.rdata = '0;
      if (hit_ena)
         rif.rdata = {2'b00, ena};
      else if (hit_raw)
         rif.rdata = {2'b00, raw};
      else if (hit_st)
         rif.rdata = {2'b00, masked};
   end

   // -----------------------------------------------------------------
   // enable word
   // -----------------------------------------------------------------

   // per-source enable, byte lanes honoured
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         ena <= PEI_RST_ENA;
      else if (i_clk_en && rif.wr && hit_ena)
         ena <= (ena & ~be_mask[PEI_NSRC-1:0])
              | (rif.wdata[PEI_NSRC-1:0] & be_mask[PEI_NSRC-1:0]);
   end

   // -----------------------------------------------------------------
   // raw flags and clearing
   // -----------------------------------------------------------------

   // ones written to the clear word, only in enabled lanes
   assign w1c_vec = (rif.wr && hit_clr) ?
                    (rif.wdata[PEI_NSRC-1:0] & be_mask[PEI_NSRC-1:0])
                    : '0;

   // a read of the masked word clears what it returned
   assign roc_vec = (rif.rd && hit_st) ?
                    o_avs_readdata[PEI_NSRC-1:0] : '0;

   assign clr_vec = w1c_vec | roc_vec;

   // sticky raw flags; an event in the clear cycle survives
   pei_flag_bank #(
      .W (PEI_NSRC)
   ) u_raw (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_clk_en  (i_clk_en),
      .i_set     (evt_vec),
      .i_clr     (clr_vec),
      .o_flags   (raw)
   );

   // masked view shares the raw layout
   assign masked = raw & ena;

   // -----------------------------------------------------------------
   // interrupt output
   // -----------------------------------------------------------------

   // level request from a flop, one cycle behind the flags
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_irq <= 1'b0;
      else if (i_clk_en)
         o_irq <= |masked;
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   // every pulsed event is visible in raw flags the next cycle
   a_raw_event_set:
      assert property (i_clk_en |=>
                       ((raw & $past(evt_vec)) == $past(evt_vec)))
      else $error("event pulse did not set its raw flag");

   // capture group lands at the top three bits
   a_capture_field:
      assert property ((i_clk_en && i_capture[2]) |=> raw[29])
      else $error("capture 2 flag not at bit 29");

   // timer zero stop lands at bit zero
   a_halt_field:
      assert property ((i_clk_en && i_timer_halt[0]) |=> raw[0])
      else $error("timer 0 stop flag not at bit 0");

   // compare a and compare b are separate flags
   a_cmp_a_b_split:
      assert property ((i_clk_en && i_operator_compare_a_event[1]
                        && !i_operator_compare_b_event[1]
                        && !raw[PEI_POS_CMP_B+1] && !clr_vec[16])
                       |=> (raw[16] && !raw[PEI_POS_CMP_B+1]))
      else $error("compare a event touched compare b flag");

   // fault start and end keep separate flags
   a_fault_split:
      assert property ((i_clk_en && i_fault_end[0] && !i_fault_start[0]
                        && !raw[PEI_POS_FAULT_BEG])
                       |=> (raw[12] && !raw[PEI_POS_FAULT_BEG]))
      else $error("fault end event touched fault start flag");

   // peak and zero keep separate flags
   a_peak_zero_split:
      assert property ((i_clk_en && i_timer_peak_event[2]
                        && !i_timer_zero_event[2] && !raw[5])
                       |=> (raw[8] && !raw[5]))
      else $error("peak event touched zero flag");

   // one-shot and cycle trips keep separate flags
   a_trip_split:
      assert property ((i_clk_en && i_one_shot_trip[1]
                        && !i_cycle_trip[1] && !raw[22])
                       |=> (raw[25] && !raw[22]))
      else $error("one-shot trip touched cycle trip flag");

   // a written one clears the flag unless an event arrives with it
   a_clear_one:
      assert property ((i_clk_en && rif.wr && hit_clr
                        && rif.be == 4'hf && rif.wdata[0]
                        && !evt_vec[0]) |=> !raw[0])
      else $error("write of one did not clear flag");

   // written zeros leave flags alone
   a_clear_zero:
      assert property ((i_clk_en && rif.wr && hit_clr
                        && rif.wdata == '0 && !(rif.rd && hit_st))
                       |=> ((raw & $past(raw)) == $past(raw)))
      else $error("write of zero cleared a flag");

   // set wins over a clear in the same cycle
   a_set_over_clr:
      assert property ((i_clk_en && clr_vec[3] && evt_vec[3])
                       |=> raw[3])
      else $error("event lost against clear");

   // flags come up clear from reset
   a_reset_clear:
      assert property (disable iff (1'b0)
                       i_srst |=> (raw == PEI_RST_RAW && !o_irq
                                   && o_avs_waitrequest
                                   && o_avs_readdata == PEI_RST_RDATA))
      else $error("raw flags not clear after reset");

   // masked read value matches raw and enable
   a_masked_read:
      assert property ((i_clk_en && i_avs_read && o_avs_waitrequest
                        && i_avs_address == PEI_OFF_ST)
                       |=> (o_avs_readdata[PEI_NSRC-1:0]
                            == $past(raw & ena)))
      else $error("masked word does not match raw and enable");

   // enable write lands in the enable word
   a_enable_write:
      assert property ((i_clk_en && rif.wr && hit_ena
                        && rif.be == 4'hf)
                       |=> (ena == $past(rif.wdata[PEI_NSRC-1:0])))
      else $error("enable word write lost");

   // interrupt follows the masked flags one cycle later
   a_irq_level:
      assert property (i_clk_en |=> (o_irq == $past(|masked)))
      else $error("interrupt level does not follow masked flags");

   // a request is answered after exactly one wait cycle
   a_bus_answer:
      assert property ((i_clk_en && (i_avs_read || i_avs_write)
                        && o_avs_waitrequest && $past(o_avs_waitrequest))
                       |=> !o_avs_waitrequest)
      else $error("waitrequest did not drop after one cycle");

   // writes to the read-only words change no flag and no enable
   a_ro_words_kept:
      assert property ((i_clk_en && rif.wr && (hit_raw || hit_st))
                       |=> (raw == ($past(raw) | $past(evt_vec))
                            && ena == $past(ena)))
      else $error("write to a read-only word changed state");

   // without a clear request no raw flag ever drops
   a_sticky_hold:
      assert property ((clr_vec == '0)
                       |=> ((raw & $past(raw)) == $past(raw)))
      else $error("raw flag dropped without a clear");

   // a masked read clears what it returned, unless an event re-sets it
   a_read_clear:
      assert property ((i_clk_en && rif.rd && hit_st)
                       |=> ((raw & $past(o_avs_readdata[PEI_NSRC-1:0]
                                      & ~evt_vec)) == '0))
      else $error("masked read left a returned flag set");

   // a clear in the low lane leaves the upper lanes alone
   a_lane_clear:
      assert property ((i_clk_en && rif.wr && hit_clr && rif.be == 4'h1)
                       |=> ((raw[PEI_NSRC-1:8] & $past(raw[PEI_NSRC-1:8]))
                            == $past(raw[PEI_NSRC-1:8])))
      else $error("clear reached a disabled byte lane");

   // the enable word changes only on a write to it
   a_enable_kept:
      assert property (!(i_clk_en && rif.wr && hit_ena)
                       |=> (ena == $past(ena)))
      else $error("enable word changed without a write");

   // bits above the last source always read as zero
   a_top_bits_zero:
      assert property (o_avs_readdata[PEI_DW-1:PEI_NSRC] == '0)
      else $error("unused read data bits not zero");

   // -----------------------------------------------------------------
   // cover points
   // -----------------------------------------------------------------

   c_irq_rise:
      cover property (!o_irq ##1 o_irq);

   c_set_and_clear:
      cover property ((rif.wr && hit_clr && evt_vec != '0));

   c_read_clear:
      cover property ((rif.rd && hit_st && o_avs_readdata != '0));

   c_all_events:
      cover property (raw == {PEI_NSRC{1'b1}});

   c_lane_write:
      cover property (rif.wr && hit_clr && rif.be != 4'hf);

endmodule : pei_event_irq
`default_nettype wire

// >>> rtl/pei_flag_bank.sv
// pei_flag_bank: sticky flags, set has priority over clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pei_flag_bank
   import pei_pkg::*;
#(
   parameter int unsigned W = PEI_NSRC
)(
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic         i_clk_en,
   input  wire logic [W-1:0] i_set,
   input  wire logic [W-1:0] i_clr,
   output logic      [W-1:0] o_flags
);

   // set wins so an event in the clearing cycle is kept
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_flags <= '0;
      else if (i_clk_en)
         o_flags <= (o_flags & ~i_clr) | i_set;
   end

endmodule : pei_flag_bank
`default_nettype wire

// >>> rtl/pei_pkg.sv
// pei_pkg: shared constants and types of the pwm event interrupt block
// assumes a 32-bit register bus with byte addresses
package pei_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int unsigned PEI_NSRC  = 30;  // event sources
   localparam int unsigned PEI_NUNIT = 3;   // channels per group
   localparam int unsigned PEI_AW    = 12;  // byte address width
   localparam int unsigned PEI_DW    = 32;  // data width

   typedef logic [PEI_NSRC-1:0] pei_flags_t;
   typedef logic [PEI_AW-1:0]   pei_addr_t;
   typedef logic [PEI_DW-1:0]   pei_data_t;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam pei_addr_t PEI_OFF_ENA = 12'h110; // event_enable_word
   localparam pei_addr_t PEI_OFF_RAW = 12'h114; // raw_event_flags
   localparam pei_addr_t PEI_OFF_ST  = 12'h118; // masked_event_flags
   localparam pei_addr_t PEI_OFF_CLR = 12'h11c; // event_flag_clear

   // -----------------------------------------------------------------
   // field positions (lsb of each three-bit group)
   // -----------------------------------------------------------------
   localparam int unsigned PEI_POS_CAPTURE   = 27;
   localparam int unsigned PEI_POS_ONE_SHOT  = 24;
   localparam int unsigned PEI_POS_CYCLE     = 21;
   localparam int unsigned PEI_POS_CMP_B     = 18;
   localparam int unsigned PEI_POS_CMP_A     = 15;
   localparam int unsigned PEI_POS_FAULT_END = 12;
   localparam int unsigned PEI_POS_FAULT_BEG = 9;
   localparam int unsigned PEI_POS_PEAK      = 6;
   localparam int unsigned PEI_POS_ZERO      = 3;
   localparam int unsigned PEI_POS_HALT      = 0;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam pei_flags_t PEI_RST_RAW = 30'h0;
   localparam pei_flags_t PEI_RST_ENA = 30'h0;
   localparam pei_data_t  PEI_RST_RDATA = 32'h0;

   // bus handshake states
   typedef enum logic {
      PEI_BUS_IDLE = 1'b0,
      PEI_BUS_ACK  = 1'b1
   } pei_bus_e;

endpackage : pei_pkg

// >>> rtl/pei_reg_if.sv
// pei_reg_if: register access strobes between bus slave and register bank
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface pei_reg_if;
   import pei_pkg::*;
   logic      rd;     // read accepted, one cycle
   logic      wr;     // write accepted, one cycle
   pei_addr_t addr;
   pei_data_t wdata;
   logic [3:0] be;
   pei_data_t rdata;  // combinational read value
   modport bus  (output rd, wr, addr, wdata, be, input rdata);
   modport regs (input rd, wr, addr, wdata, be, output rdata);
endinterface : pei_reg_if
`default_nettype wire

// >>> verif/pei_event_irq_tb.sv
// testbench: self-checking bench for the pwm event interrupt status block
// assumes pei_pkg and the rtl files are compiled first; 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench
   import pei_pkg::*;
;
   // ----------------------------------------------------------------
   // clock, stimulus and expectation state
   // ----------------------------------------------------------------
   logic       i_sys_clk = 1'b0;
   logic       i_srst    = 1'b1;
   logic       clk_en    = 1'b1;
   pei_flags_t ev        = '0;          // one pulse bit per source
   pei_addr_t  avs_address   = '0;
   logic       avs_read      = 1'b0;
   logic       avs_write     = 1'b0;
   pei_data_t  avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   pei_data_t  avs_readdata;
   logic       avs_waitrequest;
   logic       irq;
   pei_data_t  exp_q[$];                // expected read data, oldest first
   int         n_mismatch = 0;
   int         compares   = 0;
   int         cyc        = 0;
   int         seed       = 85643;
   pei_flags_t ena;
   pei_flags_t rnd;

   always #10 i_sys_clk = ~i_sys_clk;

   // event vector follows the shared word layout
   pei_event_irq u_pei_event_irq (
      .i_sys_clk                  (i_sys_clk),
      .i_srst                     (i_srst),
      .i_clk_en                   (clk_en),
      .i_capture                  (ev[29:27]),
      .i_one_shot_trip            (ev[26:24]),
      .i_cycle_trip               (ev[23:21]),
      .i_operator_compare_b_event (ev[20:18]),
      .i_operator_compare_a_event (ev[17:15]),
      .i_fault_end                (ev[14:12]),
      .i_fault_start              (ev[11:9]),
      .i_timer_peak_event         (ev[8:6]),
      .i_timer_zero_event         (ev[5:3]),
      .i_timer_halt               (ev[2:0]),
      .i_avs_address              (avs_address),
      .i_avs_read                 (avs_read),
      .i_avs_write                (avs_write),
      .i_avs_writedata            (avs_writedata),
      .i_avs_byteenable           (avs_byteenable),
      .o_avs_readdata             (avs_readdata),
      .o_avs_waitrequest          (avs_waitrequest),
      .o_irq                      (irq)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input pei_data_t seen,
                        input pei_data_t exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0 && exp_q.size() == 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   // one avalon transfer; reads leave their expectation in the queue
   task automatic bus(input logic wr, input pei_addr_t a, input pei_data_t d,
                      input logic [3:0] be, input pei_data_t exp);
      @(posedge i_sys_clk);
      if (!wr)
         exp_q.push_back(exp);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      // wait for the answer; only the cycle ceiling ends a hang
      do
         @(posedge i_sys_clk);
      while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic pulse(input pei_flags_t v);
      @(posedge i_sys_clk);
      ev <= v;
      @(posedge i_sys_clk);
      ev <= '0;
   endtask : pulse

   task automatic do_reset;
      i_srst <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      i_srst <= 1'b0;
   endtask : do_reset

   // ----------------------------------------------------------------
   // read monitor and hang guard
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (avs_read && avs_waitrequest === 1'b0)
      begin
         if (exp_q.size() == 0)
            check("unexpected read", avs_readdata, 32'h0);
         else
            check("readdata", avs_readdata, exp_q.pop_front());
      end
      if (cyc == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      do_reset();
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
      bus(1'b0, PEI_OFF_ENA, 32'h0, 4'hf, 32'h0);
      $display("test reset done");
      // each source sets only its own bit and its clear bit removes it
      for (int b = 0; b < 30; b++)
      begin
         pulse(30'h1 << b);
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h1 << b);
         bus(1'b1, PEI_OFF_CLR, 32'h1 << b, 4'hf, 32'h0);
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
      end
      // a clear and an event on the same edge: the event survives
      fork
         bus(1'b1, PEI_OFF_CLR, 32'h8, 4'hf, 32'h0);
         begin
            @(posedge i_sys_clk);
            pulse(30'h8);
         end
      join
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h8);
      bus(1'b1, PEI_OFF_CLR, 32'h8, 4'hf, 32'h0);
      $display("test per source done");
      // random enables and events: masking, interrupt, clears
      for (int k = 0; k < 8; k++)
      begin
         ena = pei_flags_t'($random(seed));
         rnd = pei_flags_t'($random(seed));
         bus(1'b1, PEI_OFF_ENA, {2'b11, ena}, 4'hf, 32'h0);
         bus(1'b0, PEI_OFF_ENA, 32'h0, 4'hf, {2'b00, ena});
         pulse(rnd);
         repeat (2) @(posedge i_sys_clk);
         check("irq", {31'h0, irq}, {31'h0, |(rnd & ena)});
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, {2'b00, rnd});
         bus(1'b0, PEI_OFF_ST, 32'h0, 4'hf, {2'b00, rnd & ena});
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, {2'b00, rnd & ~ena});
         bus(1'b1, PEI_OFF_CLR, 32'h0, 4'hf, 32'h0);
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, {2'b00, rnd & ~ena});
         bus(1'b1, PEI_OFF_CLR, 32'hffffffff, 4'hf, 32'h0);
         bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
         repeat (2) @(posedge i_sys_clk);
         check("irq low", {31'h0, irq}, 32'h0);
      end
      $display("test random mask done");
      // read-only words, unmapped address, byte lanes
      bus(1'b1, PEI_OFF_RAW, 32'hffffffff, 4'hf, 32'h0);
      bus(1'b1, PEI_OFF_ST, 32'hffffffff, 4'hf, 32'h0);
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
      bus(1'b0, PEI_OFF_CLR, 32'h0, 4'hf, 32'h0);
      bus(1'b0, 12'h200, 32'h0, 4'hf, 32'h0);
      bus(1'b1, PEI_OFF_ENA, 32'h0, 4'hf, 32'h0);
      bus(1'b1, PEI_OFF_ENA, 32'hffffffff, 4'h2, 32'h0);
      bus(1'b0, PEI_OFF_ENA, 32'h0, 4'hf, 32'h0000ff00);
      pulse(30'h3fffffff);
      bus(1'b1, PEI_OFF_CLR, 32'hffffffff, 4'h1, 32'h0);
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h3fffff00);
      $display("test refused access done");
      // events are lost while the clock enable is low
      bus(1'b1, PEI_OFF_CLR, 32'hffffffff, 4'hf, 32'h0);
      @(posedge i_sys_clk);
      clk_en <= 1'b0;
      pulse(30'h38000000);
      @(posedge i_sys_clk);
      clk_en <= 1'b1;
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
      $display("test clock enable done");
      // reset in mid-run clears flags and enables
      bus(1'b1, PEI_OFF_ENA, 32'hffffffff, 4'hf, 32'h0);
      pulse(30'h3fffffff);
      do_reset();
      bus(1'b0, PEI_OFF_RAW, 32'h0, 4'hf, 32'h0);
      bus(1'b0, PEI_OFF_ENA, 32'h0, 4'hf, 32'h0);
      check("irq after reset", {31'h0, irq}, 32'h0);
      $display("test second reset done");
      repeat (2) @(posedge i_sys_clk);
      print_verdict();
   end

endmodule : testbench
`default_nettype wire
